/* inc/trace_bypass_defines.svh */
// register offsets, field positions, reset values and limits of the bypass bank
`ifndef TRACE_BYPASS_DEFINES_SVH
`define TRACE_BYPASS_DEFINES_SVH

// register indices; the byte address on the bus is four times the index
`define OUT1_BYPASS_SWING_IDX 8'h39
`define OUT0_BYPASS_PREEMPH_IDX 8'h3A
`define OUT0_BYPASS_SWING_IDX 8'h3B
`define OUT1_BYPASS_SWING_ADDR 12'h0E4
`define OUT0_BYPASS_PREEMPH_ADDR 12'h0E8
`define OUT0_BYPASS_SWING_ADDR 12'h0EC
// block control and status words
`define BYPASS_CTRL_ADDR 12'h200
`define BYPASS_STATUS_ADDR 12'h204

// field positions
`define SWING_MSB 13
`define SWING_LSB 8
`define WIDTH_MSB 12
`define WIDTH_LSB 8
`define PWRDN_BIT 6
`define AMPL_MSB 5
`define AMPL_LSB 0
`define CTRL_OUT0_PER_RATE_BIT 0
`define CTRL_OUT1_PER_RATE_BIT 1

// reset values of whole registers
`define SWING_REG_RESET 16'h1170
`define PREEMPH_REG_RESET 16'h0201
`define CTRL_RESET 2'h0
// reset values of the driver-side field copies
`define SWING_FIELD_RESET 6'h11
`define WIDTH_FIELD_RESET 5'h02
`define AMPL_FIELD_RESET 6'h01

// largest legal field settings
`define SWING_MAX 6'h28
`define WIDTH_MAX 5'h0F
`define AMPL_MAX 6'h32

`endif

/* inc/trace_bypass_pkg.sv */
// types shared by the trace-driver bypass bank
package trace_bypass_pkg;
  typedef logic [5:0] swing_type;
  typedef logic [4:0] pulse_width_type;
  typedef logic [5:0] preemph_ampl_type;
  typedef logic [15:0] param_reg_type;
endpackage

/* design/trace_param_select.sv */
// per-output choice of the bypass parameter set
`timescale 1ns/1ps
module trace_param_select
  import trace_bypass_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic per_rate_select,
  input wire logic cdr_lock_sync,
  output logic bypass_apply_r
);

  // registered so the driver sees a clean level, one cycle behind its causes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bypass_apply_r <= 1'b0;
    end else begin
      bypass_apply_r <= per_rate_select & ~cdr_lock_sync;
    end
  end

endmodule

/* design/trace_bypass_regs.sv */
// apb register bank for the bypass-rate trace-driver parameters
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "trace_bypass_defines.svh"

// What this block does
// - output-one bypass swing, bits 13:8, settings 0 to 40, reset 11 hex.
// - default swing setting gives about 400 mV peak-to-peak differential.
// - output-zero bypass swing, own register, bits 13:8, 0 to 40, reset 11 hex.
// - output-zero pre-emphasis pulse width, bits 12:8, 0 to 15, reset 2.
// - bit 6 set powers down output-zero pre-emphasis; clear keeps it enabled.
// - output-zero pre-emphasis amplitude, bits 5:0, 0 to 50, reset 1.
// - per-rate selected and recovery loop unlocked: bypass set used at every rate.
module trace_bypass_regs
  import trace_bypass_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cdr_locked,
  output logic serial_output_zero_bypass_apply,
  output logic serial_output_one_bypass_apply,
  output logic [5:0] out0_swing,
  output logic [4:0] out0_preemph_width,
  output logic [5:0] out0_preemph_ampl,
  output logic out0_preemph_pwrdn,
  output logic out0_preemph_en,
  output logic [5:0] out1_swing
);

  param_reg_type out1_swing_reg_r;
  param_reg_type out0_preemph_reg_r;
  param_reg_type out0_swing_reg_r;
  logic out0_per_rate_select_r;
  logic out1_per_rate_select_r;
  logic lock_meta_r;
  logic lock_sync_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic access;
  logic wr_en;
  logic hit;
  logic [15:0] wdata_merged;
  logic [15:0] rd_word;
  logic [15:0] cur_word;
  swing_type out0_swing_r;
  pulse_width_type out0_width_r;
  preemph_ampl_type out0_ampl_r;
  logic out0_pwrdn_r;
  logic out0_en_r;
  swing_type out1_swing_r;

  // out-of-range settings saturate so the analog driver never sees an illegal code
  function automatic swing_type clamp_swing(input logic [5:0] v);
    clamp_swing = (v > `SWING_MAX) ? `SWING_MAX : v;
  endfunction

  function automatic pulse_width_type clamp_width(input logic [4:0] v);
    clamp_width = (v > `WIDTH_MAX) ? `WIDTH_MAX : v;
  endfunction

  function automatic preemph_ampl_type clamp_ampl(input logic [5:0] v);
    clamp_ampl = (v > `AMPL_MAX) ? `AMPL_MAX : v;
  endfunction

  // access phase; the write lands on the edge where pready is seen high
  assign access = psel & penable;
  assign wr_en = access & pwrite & pready_r;

  // address decode of the mapped words
  always_comb begin
    hit = 1'b1;
    cur_word = 16'h0000;
    unique case (paddr)
      `OUT1_BYPASS_SWING_ADDR: cur_word = out1_swing_reg_r;
      `OUT0_BYPASS_PREEMPH_ADDR: cur_word = out0_preemph_reg_r;
      `OUT0_BYPASS_SWING_ADDR: cur_word = out0_swing_reg_r;
      `BYPASS_CTRL_ADDR: cur_word = {14'h0000, out1_per_rate_select_r, out0_per_rate_select_r};
      `BYPASS_STATUS_ADDR: cur_word = {13'h0000, serial_output_one_bypass_apply,
                                       serial_output_zero_bypass_apply, lock_sync_r};
      default: hit = 1'b0;
    endcase
  end

  // byte strobes merge new data over the stored word; reserved bits are
  // stored as written, software is expected to write them back unchanged
  always_comb begin
    wdata_merged[7:0] = pstrb[0] ? pwdata[7:0] : cur_word[7:0];
    wdata_merged[15:8] = pstrb[1] ? pwdata[15:8] : cur_word[15:8];
  end

  // read word shows stored contents, upper bus bits read as zero
  assign rd_word = cur_word;

  // apb answer: one wait state, then pready for one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= access & ~pready_r;
    end
  end

  // error flag for unmapped addresses, given with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= access & ~pready_r & ~hit;
    end
  end

  // read data is loaded with pready and held until the next read answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (access & ~pready_r & ~pwrite) begin
      prdata_r <= {16'h0000, rd_word};
    end
  end

  // output-one swing register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out1_swing_reg_r <= `SWING_REG_RESET;
    end else if (wr_en && paddr == `OUT1_BYPASS_SWING_ADDR) begin
      out1_swing_reg_r <= {wdata_merged[15:14],
                           clamp_swing(wdata_merged[`SWING_MSB:`SWING_LSB]),
                           wdata_merged[7:0]};
    end
  end

  // output-zero pre-emphasis register: width, power-down, amplitude
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out0_preemph_reg_r <= `PREEMPH_REG_RESET;
    end else if (wr_en && paddr == `OUT0_BYPASS_PREEMPH_ADDR) begin
      out0_preemph_reg_r <= {wdata_merged[15:13],
                             clamp_width(wdata_merged[`WIDTH_MSB:`WIDTH_LSB]),
                             wdata_merged[7:6],
                             clamp_ampl(wdata_merged[`AMPL_MSB:`AMPL_LSB])};
    end
  end

  // output-zero swing register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out0_swing_reg_r <= `SWING_REG_RESET;
    end else if (wr_en && paddr == `OUT0_BYPASS_SWING_ADDR) begin
      out0_swing_reg_r <= {wdata_merged[15:14],
                           clamp_swing(wdata_merged[`SWING_MSB:`SWING_LSB]),
                           wdata_merged[7:0]};
    end
  end

  // per-rate select controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out0_per_rate_select_r <= 1'b0;
      out1_per_rate_select_r <= 1'b0;
    end else if (wr_en && paddr == `BYPASS_CTRL_ADDR) begin
      out0_per_rate_select_r <= wdata_merged[`CTRL_OUT0_PER_RATE_BIT];
      out1_per_rate_select_r <= wdata_merged[`CTRL_OUT1_PER_RATE_BIT];
    end
  end

  // lock level comes from the analog recovery loop, so it is synchronised
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_meta_r <= 1'b0;
      lock_sync_r <= 1'b0;
    end else begin
      lock_meta_r <= cdr_locked;
      lock_sync_r <= lock_meta_r;
    end
  end

  // bypass selection for each output
  trace_param_select u_sel0 (
    .pclk(pclk),
    .presetn(presetn),
    .per_rate_select(out0_per_rate_select_r),
    .cdr_lock_sync(lock_sync_r),
    .bypass_apply_r(serial_output_zero_bypass_apply)
  );

  trace_param_select u_sel1 (
    .pclk(pclk),
    .presetn(presetn),
    .per_rate_select(out1_per_rate_select_r),
    .cdr_lock_sync(lock_sync_r),
    .bypass_apply_r(serial_output_one_bypass_apply)
  );

  // driver copies follow the registers every cycle, so a write is live
  // one cycle after it lands with no reset or re-selection needed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out0_swing_r <= `SWING_FIELD_RESET;
      out1_swing_r <= `SWING_FIELD_RESET;
    end else begin
      out0_swing_r <= out0_swing_reg_r[`SWING_MSB:`SWING_LSB];
      out1_swing_r <= out1_swing_reg_r[`SWING_MSB:`SWING_LSB];
    end
  end

  // pre-emphasis copies; power-down and enable are always complementary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out0_width_r <= `WIDTH_FIELD_RESET;
      out0_ampl_r <= `AMPL_FIELD_RESET;
      out0_pwrdn_r <= 1'b0;
      out0_en_r <= 1'b1;
    end else begin
      out0_width_r <= out0_preemph_reg_r[`WIDTH_MSB:`WIDTH_LSB];
      out0_ampl_r <= out0_preemph_reg_r[`AMPL_MSB:`AMPL_LSB];
      out0_pwrdn_r <= out0_preemph_reg_r[`PWRDN_BIT];
      out0_en_r <= ~out0_preemph_reg_r[`PWRDN_BIT];
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign out0_swing = out0_swing_r;
  assign out1_swing = out1_swing_r;
  assign out0_preemph_width = out0_width_r;
  assign out0_preemph_ampl = out0_ampl_r;
  assign out0_preemph_pwrdn = out0_pwrdn_r;
  assign out0_preemph_en = out0_en_r;

endmodule

/* verification/cdr_lock_model.sv */
// behavioural recovery-loop lock source facing the bank
`timescale 1ns/1ps
module cdr_lock_model (
  input wire logic pclk,
  input wire logic want_lock,
  output logic cdr_locked
);
  // lock moves only after an edge so the synchroniser sees clean steps
  always_ff @(posedge pclk) begin
    cdr_locked <= want_lock;
  end
endmodule

/* verification/trace_bypass_properties.sv */
// assertions on the ports of the bypass register bank
`timescale 1ns/1ps
module trace_bypass_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic cdr_locked,
  input wire logic serial_output_zero_bypass_apply,
  input wire logic serial_output_one_bypass_apply,
  input wire logic [5:0] out0_swing,
  input wire logic [4:0] out0_preemph_width,
  input wire logic [5:0] out0_preemph_ampl,
  input wire logic out0_preemph_pwrdn,
  input wire logic out0_preemph_en,
  input wire logic [5:0] out1_swing
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // out-of-range writes saturate, so expectations clamp too
  function automatic logic [5:0] lim(input logic [5:0] v, input logic [5:0] m);
    return (v > m) ? m : v;
  endfunction
  // completed write to address a with byte lane s enabled
  sequence s_wr(a, s);
    psel && penable && pready && pwrite && paddr == a && s;
  endsequence
  property p_sw1; s_wr(12'h0E4, pstrb[1]) |=> ##1 out1_swing == lim($past(pwdata[13:8], 2), 6'h28); endproperty
  property p_sw0; s_wr(12'h0EC, pstrb[1]) |=> ##1 out0_swing == lim($past(pwdata[13:8], 2), 6'h28); endproperty
  property p_wd;
    s_wr(12'h0E8, pstrb[1]) |=> ##1 {1'b0, out0_preemph_width} == lim({1'b0, $past(pwdata[12:8], 2)}, 6'h0F);
  endproperty
  property p_am; s_wr(12'h0E8, pstrb[0]) |=> ##1 out0_preemph_ampl == lim($past(pwdata[5:0], 2), 6'h32); endproperty
  property p_pd; s_wr(12'h0E8, pstrb[0]) |=> ##1 out0_preemph_pwrdn == $past(pwdata[6], 2); endproperty
  property p_en; out0_preemph_en == !out0_preemph_pwrdn; endproperty
  property p_lock; cdr_locked [*3] |=> !serial_output_zero_bypass_apply && !serial_output_one_bypass_apply; endproperty
  property p_rng; out0_swing <= 6'h28 && out1_swing <= 6'h28; endproperty
  a_sw1: assert property (p_sw1) else $error("out1 swing wrong");
  a_sw0: assert property (p_sw0) else $error("out0 swing wrong");
  a_wd: assert property (p_wd) else $error("width wrong");
  a_am: assert property (p_am) else $error("amplitude wrong");
  a_pd: assert property (p_pd) else $error("power-down wrong");
  a_en: assert property (p_en) else $error("enable not inverse");
  a_lock: assert property (p_lock) else $error("bypass applied while locked");
  a_rng: assert property (p_rng) else $error("swing out of range");
endmodule
bind trace_bypass_regs trace_bypass_properties u_trace_bypass_properties (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pstrb(pstrb),
  .pready(pready),
  .cdr_locked(cdr_locked),
  .serial_output_zero_bypass_apply(serial_output_zero_bypass_apply),
  .serial_output_one_bypass_apply(serial_output_one_bypass_apply),
  .out0_swing(out0_swing),
  .out0_preemph_width(out0_preemph_width),
  .out0_preemph_ampl(out0_preemph_ampl),
  .out0_preemph_pwrdn(out0_preemph_pwrdn),
  .out0_preemph_en(out0_preemph_en),
  .out1_swing(out1_swing)
);

/* verification/tb.sv */
// self-checking bench for the bypass register bank
`timescale 1ns/1ps
module tb;
  import trace_bypass_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic want_lock = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [11:0] ad;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h3;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, err, cdr_locked, serial_output_zero_bypass_apply, serial_output_one_bypass_apply;
  logic [5:0] out0_swing, out1_swing, out0_preemph_ampl, f, m0, m1, ma, we;
  logic [4:0] out0_preemph_width, g, mw;
  logic out0_preemph_pwrdn, out0_preemph_en, mp;
  int num_errors = 0;
  int checks = 0;
  always #2 pclk = ~pclk;
  cdr_lock_model u_cdr_lock_model (
    .pclk(pclk),
    .want_lock(want_lock),
    .cdr_locked(cdr_locked)
  );
  trace_bypass_regs u_trace_bypass_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cdr_locked(cdr_locked),
    .serial_output_zero_bypass_apply(serial_output_zero_bypass_apply),
    .serial_output_one_bypass_apply(serial_output_one_bypass_apply),
    .out0_swing(out0_swing),
    .out0_preemph_width(out0_preemph_width),
    .out0_preemph_ampl(out0_preemph_ampl),
    .out0_preemph_pwrdn(out0_preemph_pwrdn),
    .out0_preemph_en(out0_preemph_en),
    .out1_swing(out1_swing)
  );
  function automatic logic [5:0] lim(input logic [5:0] v, input logic [5:0] m);
    return (v > m) ? m : v;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one transfer; a slave that never answers is cut off after 20 cycles
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) num_errors++;
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task outs;
    chk({out1_swing, out0_swing, out0_preemph_width, out0_preemph_ampl, out0_preemph_pwrdn, out0_preemph_en},
      {m1, m0, mw, ma, mp, ~mp});
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // watchdog sized well beyond the few hundred cycles the tests need
  initial begin
    #40000;
    num_errors++;
    give_verdict;
  end
  initial begin
    void'($urandom(69994));
    m0 = 6'h11;
    m1 = 6'h11;
    mw = 5'h02;
    ma = 6'h01;
    mp = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    outs;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 12'h0E4 + 12'(4 * i), 32'h0);
      chk(rdata, (i == 1) ? 32'h00000201 : 32'h00001170);
      chk({31'h0, err}, 32'h0);
    end
    $display("reset test done");
    // reserved bits are written back at their reset values
    for (int i = 0; i < 24; i++) begin
      f = (i < 3) ? 6'h3F : (i < 6) ? 6'h28 : 6'($urandom_range(0, 63));
      g = (i < 3) ? 5'h1F : 5'($urandom_range(0, 31));
      ad = 12'h0E4 + 12'(4 * (i % 3));
      if (ad == 12'h0E8) begin
        apb(1'b1, ad, {19'h0, g, 1'b0, g[4], f});
        we = lim({1'b0, g}, 6'h0F);
        mw = we[4:0];
        ma = lim(f, 6'h32);
        mp = g[4];
        apb(1'b0, ad, 32'h0);
        chk(rdata, {19'h0, mw, 1'b0, mp, ma});
      end else begin
        apb(1'b1, ad, {18'h0, f, 8'h70});
        if (ad == 12'h0E4) m1 = lim(f, 6'h28);
        else m0 = lim(f, 6'h28);
        apb(1'b0, ad, 32'h0);
        chk(rdata, {18'h0, lim(f, 6'h28), 8'h70});
      end
      outs;
    end
    $display("random test done");
    apb(1'b1, 12'h100, 32'h0000FFFF);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 12'h100, 32'h0);
    chk({rdata[30:0], err}, 32'h1);
    outs;
    // upper byte strobe off: the swing field must keep its value
    pstrb <= 4'h1;
    apb(1'b1, 12'h0E4, 32'h00000570);
    pstrb <= 4'h3;
    apb(1'b0, 12'h0E4, 32'h0);
    chk(rdata, {18'h0, m1, 8'h70});
    outs;
    $display("refusal test done");
    for (int k = 1; k < 3; k++) begin
      apb(1'b1, 12'h200, 32'(k));
      repeat (3) @(posedge pclk);
      chk({serial_output_one_bypass_apply, serial_output_zero_bypass_apply}, 32'(k));
    end
    apb(1'b1, 12'h200, 32'h3);
    want_lock <= 1'b1;
    repeat (6) @(posedge pclk);
    chk({serial_output_one_bypass_apply, serial_output_zero_bypass_apply}, 32'h0);
    // status word: synced lock set, both apply flags clear
    apb(1'b0, 12'h204, 32'h0);
    chk(rdata, 32'h1);
    $display("apply test done");
    give_verdict;
  end
endmodule
